/* File: rtl/spc_pkg.sv */
// Package of register map, field positions and types for the serial port control block
package spc_pkg;
    localparam logic [11:0] TX_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] RX_CTRL_OFFSET = 12'h004;
    localparam logic [11:0] BAUD_CTRL_OFFSET = 12'h008;
    localparam logic [11:0] DIV_LOW_OFFSET = 12'h00c;
    localparam logic [11:0] DIV_HIGH_OFFSET = 12'h010;
    localparam logic [11:0] EVENT_OFFSET = 12'h014;
    // transmit_status_control fields
    localparam int CLOCK_SOURCE_POS = 7;
    localparam int TX_NINE_POS = 6;
    localparam int TX_ENABLE_POS = 5;
    localparam int MODE_SYNC_POS = 4;
    localparam int BREAK_REQ_POS = 3;
    localparam int HIGH_SPEED_POS = 2;
    localparam int TSR_EMPTY_POS = 1;
    localparam int TX_NINTH_POS = 0;
    // receive_status_control fields
    localparam int PORT_ENABLE_POS = 7;
    localparam int RX_NINE_POS = 6;
    localparam int SINGLE_RX_POS = 5;
    localparam int CONT_RX_POS = 4;
    localparam int ADDR_DETECT_POS = 3;
    localparam int FRAMING_POS = 2;
    localparam int OVERRUN_POS = 1;
    localparam int RX_NINTH_POS = 0;
    // baud_rate_control fields
    localparam int AB_OVF_POS = 7;
    localparam int RX_IDLE_POS = 6;
    localparam int POLARITY_POS = 4;
    localparam int SIXTEEN_POS = 3;
    localparam int WAKEUP_POS = 1;
    localparam int AUTOBAUD_POS = 0;
    // Writable masks and reset values
    localparam logic [7:0] TX_CTRL_WMASK = 8'hfd;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
    localparam logic [7:0] BAUD_CTRL_WMASK = 8'h1b;
    localparam logic [7:0] TX_CTRL_RESET = 8'h00;
    localparam logic [7:0] RX_CTRL_RESET = 8'h00;
    localparam logic [7:0] BAUD_CTRL_RESET = 8'h00;
    // Baud multipliers minus one
    localparam logic [5:0] MULT_ASYNC8_LOW = 6'h3f;
    localparam logic [5:0] MULT_ASYNC_MID = 6'h0f;
    localparam logic [5:0] MULT_SYNC = 6'h03;

    typedef struct packed {
        logic break_done;
        logic tx_load;
        logic tx_shift_done;
        logic rx_start;
        logic rx_done;
        logic rx_ninth;
        logic rx_framing;
        logic rx_overrun;
        logic ab_done;
        logic ab_overflow;
        logic wake_edge;
    } spc_events_t;

    typedef struct packed {
        logic port_on;
        logic sync_mode;
        logic master;
        logic tx_active;
        logic rx_active;
        logic nine_tx;
        logic nine_rx;
        logic ninth_tx;
        logic addr_detect;
        logic polarity;
        logic break_pending;
        logic wakeup;
        logic autobaud;
    } spc_ctrl_t;
endpackage

/* File: rtl/spc_top.sv */
// Serial port control registers, status flags and baud generator behind an APB slave
`timescale 1ns/1ps
// Contract
// - Sync mode clock source: master or slave
// - Transmit nine-bit select sets character length
// - Transmit enable; sync receive enables override it
// - Mode bit selects synchronous or asynchronous
// - Break request sends break, hardware clears
// - Shift register empty flag, resets to one
// - Transmit ninth bit supplies ninth data
// - Port enable; clear holds port reset
// - Receive nine-bit select sets character length
// - Single receive in sync master, self-clears
// - Continuous receive enables; overrides single receive
// - Address detect accepts only ninth-bit-set characters
// - Framing flag updates on read and receive
// - Overrun clears when continuous receive clears
// - Auto-baud overflow flag set on timer overflow
// - Receive idle flag, resets to one
// - Polarity inverts async data or selects edge
// - Wake-up waits falling edge, sets flag, clears
// - Auto-baud enable starts detection, self-clears
// - Baud generator 8 or 16 bit free-running
// - Speed bits set multiplier; divisor write resets
// - Baud divides clock by 64, 16, 4 times n+1
module spc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spc_pkg::spc_events_t events,
    input wire logic rx_data_read,
    input wire logic rx_pin,
    output spc_pkg::spc_ctrl_t ctrl,
    output logic baud_tick,
    output logic receive_interrupt_flag
);
    import spc_pkg::*;

    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [7:0] baud_ctrl;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic tsr_empty;
    logic framing;
    logic overrun;
    logic rx_ninth;
    logic ab_ovf;
    logic rx_idle;
    logic [15:0] brg_count;
    logic [5:0] mult_count;
    logic [2:0] rx_sync;
    logic rx_stable;
    logic rx_prev;
    logic wake_fall;
    logic access;
    logic wr;
    logic rd;
    logic div_write;
    logic sync_m;
    logic port_on;
    logic [15:0] divisor;
    logic [5:0] mult_max;
    logic brg_wrap;

    assign access = psel && penable;
    assign wr = access && pwrite && pstrb[0];
    assign rd = access && !pwrite;
    assign sync_m = tx_ctrl[MODE_SYNC_POS];
    assign port_on = rx_ctrl[PORT_ENABLE_POS];
    assign div_write = wr && (paddr == DIV_LOW_OFFSET || paddr == DIV_HIGH_OFFSET);

    // Port enable itself survives the port reset so software can turn it on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ctrl <= TX_CTRL_RESET;
        end else if (!port_on) begin
            tx_ctrl <= TX_CTRL_RESET;
        end else if (wr && paddr == TX_CTRL_OFFSET) begin
            tx_ctrl <= pwdata[7:0] & TX_CTRL_WMASK;
        end else if (events.break_done && !sync_m) begin
            tx_ctrl[BREAK_REQ_POS] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctrl <= RX_CTRL_RESET;
        end else if (wr && paddr == RX_CTRL_OFFSET) begin
            rx_ctrl <= pwdata[7:0] & RX_CTRL_WMASK;
            if (!pwdata[PORT_ENABLE_POS]) begin
                rx_ctrl <= RX_CTRL_RESET;
            end
        end else if (events.rx_done && sync_m && tx_ctrl[CLOCK_SOURCE_POS]
                     && !rx_ctrl[CONT_RX_POS]) begin
            rx_ctrl[SINGLE_RX_POS] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_ctrl <= BAUD_CTRL_RESET;
        end else if (!port_on) begin
            baud_ctrl <= BAUD_CTRL_RESET;
        end else if (wr && paddr == BAUD_CTRL_OFFSET) begin
            baud_ctrl <= pwdata[7:0] & BAUD_CTRL_WMASK;
        end else begin
            if (events.ab_done && !sync_m) begin
                baud_ctrl[AUTOBAUD_POS] <= 1'b0;
            end
            if (wake_fall) begin
                baud_ctrl[WAKEUP_POS] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_low <= 8'h00;
            div_high <= 8'h00;
        end else if (wr && paddr == DIV_LOW_OFFSET) begin
            div_low <= pwdata[7:0];
        end else if (wr && paddr == DIV_HIGH_OFFSET) begin
            div_high <= pwdata[7:0];
        end
    end

    // Status flags; a hardware set wins over the clearing condition for overrun and ab_ovf, while tx_load and rx_start win for tsr_empty and rx_idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsr_empty <= 1'b1;
            framing <= 1'b0;
            overrun <= 1'b0;
            rx_ninth <= 1'b0;
            ab_ovf <= 1'b0;
            rx_idle <= 1'b1;
        end else if (!port_on) begin
            tsr_empty <= 1'b1;
            framing <= 1'b0;
            overrun <= 1'b0;
            rx_ninth <= 1'b0;
            ab_ovf <= 1'b0;
            rx_idle <= 1'b1;
        end else begin
            if (events.tx_load) begin
                tsr_empty <= 1'b0;
            end else if (events.tx_shift_done) begin
                tsr_empty <= 1'b1;
            end
            if (events.rx_done || rx_data_read) begin
                framing <= events.rx_framing;
                rx_ninth <= events.rx_ninth;
            end
            if (events.rx_overrun) begin
                overrun <= 1'b1;
            end else if (!rx_ctrl[CONT_RX_POS]) begin
                overrun <= 1'b0;
            end
            if (!sync_m && events.ab_overflow) begin
                ab_ovf <= 1'b1;
            end else if (!baud_ctrl[AUTOBAUD_POS]) begin
                ab_ovf <= 1'b0;
            end
            if (!sync_m && events.rx_start) begin
                rx_idle <= 1'b0;
            end else if (events.rx_done) begin
                rx_idle <= 1'b1;
            end
        end
    end

    // Three-stage synchroniser; only stages two and three are compared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync <= 3'b111;
            rx_stable <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_pin};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_stable <= rx_sync[2];
            end
            rx_prev <= rx_stable;
        end
    end

    assign wake_fall = port_on && !sync_m && baud_ctrl[WAKEUP_POS] && rx_prev && !rx_stable;

    // Receive flag: address filter in nine-bit async, or wake-up edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_interrupt_flag <= 1'b0;
        end else if (!port_on) begin
            receive_interrupt_flag <= 1'b0;
        end else if (wake_fall) begin
            receive_interrupt_flag <= 1'b1;
        end else if (events.rx_done && !baud_ctrl[WAKEUP_POS]
                     && (!(rx_ctrl[ADDR_DETECT_POS] && rx_ctrl[RX_NINE_POS] && !sync_m)
                         || events.rx_ninth)) begin
            receive_interrupt_flag <= 1'b1;
        end else if (rx_data_read) begin
            receive_interrupt_flag <= 1'b0;
        end
    end

    // Baud generator
    assign divisor = baud_ctrl[SIXTEEN_POS] ? {div_high, div_low} : {8'h00, div_low};
    always_comb begin
        if (sync_m) begin
            mult_max = MULT_SYNC;
        end else if (baud_ctrl[SIXTEEN_POS] || tx_ctrl[HIGH_SPEED_POS]) begin
            mult_max = MULT_ASYNC_MID;
        end else begin
            mult_max = MULT_ASYNC8_LOW;
        end
    end
    assign brg_wrap = (mult_count >= mult_max);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_count <= 6'h00;
            brg_count <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (!port_on || div_write) begin
            mult_count <= 6'h00;
            brg_count <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (brg_wrap) begin
            mult_count <= 6'h00;
            baud_tick <= (brg_count >= divisor);
            brg_count <= (brg_count >= divisor) ? 16'h0000 : brg_count + 16'h0001;
        end else begin
            mult_count <= mult_count + 6'h01;
            baud_tick <= 1'b0;
        end
    end

    // Control outputs to shifter logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else begin
            ctrl.port_on <= port_on;
            ctrl.sync_mode <= sync_m;
            ctrl.master <= sync_m && tx_ctrl[CLOCK_SOURCE_POS];
            ctrl.tx_active <= port_on && tx_ctrl[TX_ENABLE_POS]
                && !(sync_m && (rx_ctrl[SINGLE_RX_POS] || rx_ctrl[CONT_RX_POS]));
            ctrl.rx_active <= port_on && (rx_ctrl[CONT_RX_POS] || (sync_m
                && tx_ctrl[CLOCK_SOURCE_POS] && rx_ctrl[SINGLE_RX_POS]));
            ctrl.nine_tx <= tx_ctrl[TX_NINE_POS];
            ctrl.nine_rx <= rx_ctrl[RX_NINE_POS];
            ctrl.ninth_tx <= tx_ctrl[TX_NINTH_POS];
            ctrl.addr_detect <= !sync_m && rx_ctrl[RX_NINE_POS] && rx_ctrl[ADDR_DETECT_POS];
            ctrl.polarity <= baud_ctrl[POLARITY_POS];
            ctrl.break_pending <= !sync_m && tx_ctrl[BREAK_REQ_POS];
            ctrl.wakeup <= !sync_m && baud_ctrl[WAKEUP_POS];
            ctrl.autobaud <= !sync_m && baud_ctrl[AUTOBAUD_POS];
        end
    end

    // APB read path; zero-wait, unmapped reads zero with error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == TX_CTRL_OFFSET) begin
                    prdata[7:0] <= {tx_ctrl[7:2], tsr_empty, tx_ctrl[0]};
                end else if (paddr == RX_CTRL_OFFSET) begin
                    prdata[7:0] <= {rx_ctrl[7:3], framing, overrun, rx_ninth};
                end else if (paddr == BAUD_CTRL_OFFSET) begin
                    prdata[7:0] <= {ab_ovf, rx_idle, 1'b0, baud_ctrl[4:3], 1'b0, baud_ctrl[1:0]};
                end else if (paddr == DIV_LOW_OFFSET) begin
                    prdata[7:0] <= div_low;
                end else if (paddr == DIV_HIGH_OFFSET) begin
                    prdata[7:0] <= div_high;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    property p_break_clear;
        @(posedge pclk) disable iff (!presetn)
        (port_on && !sync_m && events.break_done && !wr) |=> !tx_ctrl[BREAK_REQ_POS];
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break not cleared");

    property p_tx_override;
        @(posedge pclk) disable iff (!presetn)
        (sync_m && rx_ctrl[CONT_RX_POS]) |=> !ctrl.tx_active;
    endproperty
    a_tx_override: assert property (p_tx_override) else $error("tx not overridden");

    property p_overrun_clear;
        @(posedge pclk) disable iff (!presetn)
        (!rx_ctrl[CONT_RX_POS] && !events.rx_overrun) |=> !overrun;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun stuck");

    property p_port_off;
        @(posedge pclk) disable iff (!presetn)
        !port_on |=> (tx_ctrl == TX_CTRL_RESET && !receive_interrupt_flag);
    endproperty
    a_port_off: assert property (p_port_off) else $error("port not held in reset");

    property p_div_reset;
        @(posedge pclk) disable iff (!presetn)
        div_write |=> (brg_count == 16'h0000 && mult_count == 6'h00);
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("generator not reset");

    property p_addr_filter;
        @(posedge pclk) disable iff (!presetn)
        (port_on && !receive_interrupt_flag && events.rx_done && !events.rx_ninth && !wake_fall
         && !sync_m && rx_ctrl[ADDR_DETECT_POS] && rx_ctrl[RX_NINE_POS]) |=> !receive_interrupt_flag;
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("address filter leak");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        wake_fall |=> (receive_interrupt_flag && !baud_ctrl[WAKEUP_POS]);
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up not handled");

    // A divisor write inside the gap restarts the count; a mode change alters the multiplier
    sequence s_tick_spacing;
        !baud_tick [*3] ##1 baud_tick;
    endsequence
    sequence s_tick_disturbed;
        ##[0:2] (div_write || !port_on || !sync_m || divisor != 16'h0000);
    endsequence
    property p_tick_rate;
        @(posedge pclk) disable iff (!presetn)
        (baud_tick && port_on && sync_m && divisor == 16'h0000 && !div_write)
            |=> (s_tick_spacing or s_tick_disturbed);
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("sync tick spacing");
endmodule

/* File: testbench/spc_far_model.sv */
// Far-side model: shifter event pulses and the receive pin
`timescale 1ns/1ps
module spc_far_model (
    input wire logic pclk,
    output spc_pkg::spc_events_t events,
    output logic rx_pin
);
    import spc_pkg::*;
    initial begin
        events = '0;
        rx_pin = 1'b1;
    end
    // Events last one cycle, launched just after an edge
    task automatic pulse(input spc_events_t ev);
        @(posedge pclk);
        events <= ev;
        @(posedge pclk);
        events <= '0;
    endtask
    // Idle-high line falls, as a start bit would
    task automatic drop_line();
        @(posedge pclk);
        rx_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        rx_pin <= 1'b1;
    endtask
endmodule

/* File: testbench/test_serial_port_control_and_baud_generator.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
module test_serial_port_control_and_baud_generator;
    import spc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, rx_data_read, rx_pin, e;
    logic pready, pslverr, baud_tick, receive_interrupt_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [7:0] tv, rv, bv;
    spc_events_t events;
    spc_ctrl_t ctrl;
    int err_total = 0, n_checks = 0, seed = 75, p, n, k;
    logic [2:0] modes [6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101, 3'b110};

    spc_top spc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .rx_data_read(rx_data_read),
        .rx_pin(rx_pin), .ctrl(ctrl), .baud_tick(baud_tick),
        .receive_interrupt_flag(receive_interrupt_flag));
    spc_far_model spc_far_model_i (.pclk(pclk), .events(events), .rx_pin(rx_pin));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Request holds until pready is seen high at a rising edge; data taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        if (t >= 40) begin
            err_total++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, x}, q);
        chk("slverr", 32'h0, {31'h0, e});
    endtask

    task automatic read_pulse();
        @(posedge pclk);
        rx_data_read <= 1'b1;
        @(posedge pclk);
        rx_data_read <= 1'b0;
        @(negedge pclk);
    endtask

    // Clock cycles counted from one tick to the next
    task automatic gap(output int per);
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (baud_tick !== 1'b1 && k < 5000);
        per = 0;
        do begin
            @(negedge pclk);
            per++;
        end while (baud_tick !== 1'b1 && per < 5000);
    endtask

    function automatic int exp_period(input logic [2:0] m, input int dv);
        int d;
        d = m[1] ? 256 + dv + 1 : dv + 1;
        if (m[2]) return 4 * d;
        return ((m[1] | m[0]) ? 16 : 64) * d;
    endfunction

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        rx_data_read = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(TX_CTRL_OFFSET, 8'h02);
        rd(RX_CTRL_OFFSET, 8'h00);
        rd(BAUD_CTRL_OFFSET, 8'h40);
        wr(TX_CTRL_OFFSET, 8'hf5);
        rd(TX_CTRL_OFFSET, 8'h02);
        apb(1'b0, EVENT_OFFSET, 8'h00);
        chk("unmapped slverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        // Lane 0 strobe low: the write must be ignored
        @(posedge pclk);
        pstrb <= 4'he;
        wr(DIV_LOW_OFFSET, 8'h55);
        pstrb <= 4'hf;
        rd(DIV_LOW_OFFSET, 8'h00);
        repeat (4) begin
            rv = 8'h80 | (8'($random(seed)) & 8'h78);
            tv = 8'($random(seed)) & 8'hf5;
            bv = 8'($random(seed)) & 8'h1b;
            wr(RX_CTRL_OFFSET, rv);
            wr(TX_CTRL_OFFSET, tv);
            wr(BAUD_CTRL_OFFSET, bv);
            rd(RX_CTRL_OFFSET, rv);
            rd(TX_CTRL_OFFSET, tv | 8'h02);
            rd(BAUD_CTRL_OFFSET, bv | 8'h40);
            chk("master", {31'h0, tv[7] & tv[4]}, {31'h0, ctrl.master});
            chk("sync", {31'h0, tv[4]}, {31'h0, ctrl.sync_mode});
            chk("nine tx", {31'h0, tv[6]}, {31'h0, ctrl.nine_tx});
            chk("polarity", {31'h0, bv[4]}, {31'h0, ctrl.polarity});
            chk("port on", 32'h1, {31'h0, ctrl.port_on});
            chk("tx active", {31'h0, tv[5] & ~(tv[4] & (rv[5] | rv[4]))},
                {31'h0, ctrl.tx_active});
            chk("rx active", {31'h0, rv[4] | (tv[4] & tv[7] & rv[5])},
                {31'h0, ctrl.rx_active});
            chk("nine rx", {31'h0, rv[6]}, {31'h0, ctrl.nine_rx});
            chk("ninth tx", {31'h0, tv[0]}, {31'h0, ctrl.ninth_tx});
            chk("addr detect", {31'h0, ~tv[4] & rv[6] & rv[3]}, {31'h0, ctrl.addr_detect});
            chk("break", {31'h0, ~tv[4] & tv[3]}, {31'h0, ctrl.break_pending});
            chk("wakeup", {31'h0, ~tv[4] & bv[1]}, {31'h0, ctrl.wakeup});
            chk("autobaud", {31'h0, ~tv[4] & bv[0]}, {31'h0, ctrl.autobaud});
        end
        wr(RX_CTRL_OFFSET, 8'hd0);
        wr(TX_CTRL_OFFSET, 8'h28);
        wr(BAUD_CTRL_OFFSET, 8'h00);
        rd(TX_CTRL_OFFSET, 8'h2a);
        spc_far_model_i.pulse('{break_done: 1'b1, default: 1'b0});
        rd(TX_CTRL_OFFSET, 8'h22);
        spc_far_model_i.pulse('{tx_load: 1'b1, default: 1'b0});
        rd(TX_CTRL_OFFSET, 8'h20);
        spc_far_model_i.pulse('{tx_shift_done: 1'b1, default: 1'b0});
        rd(TX_CTRL_OFFSET, 8'h22);
        spc_far_model_i.pulse('{rx_start: 1'b1, default: 1'b0});
        rd(BAUD_CTRL_OFFSET, 8'h00);
        spc_far_model_i.pulse('{rx_done: 1'b1, rx_ninth: 1'b1, rx_framing: 1'b1, default: 1'b0});
        rd(BAUD_CTRL_OFFSET, 8'h40);
        rd(RX_CTRL_OFFSET, 8'hd5);
        chk("rx flag", 32'h1, {31'h0, receive_interrupt_flag});
        read_pulse();
        chk("rx flag", 32'h0, {31'h0, receive_interrupt_flag});
        rd(RX_CTRL_OFFSET, 8'hd0);
        spc_far_model_i.pulse('{rx_overrun: 1'b1, default: 1'b0});
        rd(RX_CTRL_OFFSET, 8'hd2);
        wr(RX_CTRL_OFFSET, 8'hc0);
        rd(RX_CTRL_OFFSET, 8'hc0);
        wr(RX_CTRL_OFFSET, 8'hd8);
        spc_far_model_i.pulse('{rx_done: 1'b1, default: 1'b0});
        @(negedge pclk);
        chk("addr flag", 32'h0, {31'h0, receive_interrupt_flag});
        spc_far_model_i.pulse('{rx_done: 1'b1, rx_ninth: 1'b1, default: 1'b0});
        @(negedge pclk);
        chk("addr flag", 32'h1, {31'h0, receive_interrupt_flag});
        read_pulse();
        wr(BAUD_CTRL_OFFSET, 8'h02);
        spc_far_model_i.drop_line();
        k = 0;
        while (receive_interrupt_flag !== 1'b1 && k < 20) begin
            @(negedge pclk);
            k++;
        end
        chk("wake flag", 32'h1, {31'h0, receive_interrupt_flag});
        rd(BAUD_CTRL_OFFSET, 8'h40);
        wr(BAUD_CTRL_OFFSET, 8'h01);
        spc_far_model_i.pulse('{ab_overflow: 1'b1, default: 1'b0});
        rd(BAUD_CTRL_OFFSET, 8'hc1);
        chk("autobaud on", 32'h1, {31'h0, ctrl.autobaud});
        spc_far_model_i.pulse('{ab_done: 1'b1, default: 1'b0});
        rd(BAUD_CTRL_OFFSET, 8'h40);
        // High byte nonzero: the 8-bit modes must ignore it
        wr(DIV_HIGH_OFFSET, 8'h01);
        foreach (modes[i]) begin
            // Corner: sync with divisor zero, the shortest period
            n = (i == 3) ? 0 : $random(seed) & 3;
            wr(BAUD_CTRL_OFFSET, {4'h0, modes[i][1], 3'h0});
            wr(TX_CTRL_OFFSET, {modes[i][2], 2'h0, modes[i][2], 1'b0, modes[i][0], 2'h0});
            wr(DIV_LOW_OFFSET, n[7:0]);
            gap(p);
            chk("baud period", exp_period(modes[i], n), p);
        end
        wr(RX_CTRL_OFFSET, 8'h00);
        rd(TX_CTRL_OFFSET, 8'h02);
        end_sim();
    end
endmodule
